// ### verilog/tcsu_defs.svh
`ifndef TCSU_DEFS_SVH
`define TCSU_DEFS_SVH

// Reserved vector regions, byte addresses
`define TCSU_INT_VEC_BASE 16'h0000
`define TCSU_INT_VEC_WORDS 32
`define TCSU_EXT_OP_VEC_BASE 16'h0040
`define TCSU_EXT_OP_VEC_WORDS 32
`define TCSU_COLD_VEC_WS 16'hfffc
`define TCSU_COLD_VEC_CTR 16'hfffe

// Workspace geometry and save slots
`define TCSU_WS_WORDS 16
`define TCSU_SAVED_WS_REG 4'hd
`define TCSU_SAVED_CTR_REG 4'he
`define TCSU_SAVED_SW_REG 4'hf

// Address steps
`define TCSU_WORD_STEP 16'h0002
`define TCSU_CTR_STEP 16'h0002

// State word mask field; word bit 0 is the MSB, so bits 12..15 are [3:0]
`define TCSU_MASK_MSB 3
`define TCSU_MASK_LSB 0
`define TCSU_MASK_ZERO 4'h0
`define TCSU_LEVEL_TOP 4'h0
`define TCSU_LEVEL_STEP 4'h1

// Reset values
`define TCSU_SW_RESET 16'h0000
`define TCSU_CTR_RESET 16'h0000
`define TCSU_WS_RESET 16'h0000
`define TCSU_PIN_IDLE 6'h3f

`endif

// ### verilog/tcsu_pkg.sv
package tcsu_pkg;

   // Context-switching instruction and workspace register read requests from the execution core
   typedef enum logic [1:0] {
      TCSU_OP_BRANCH_LOAD_CONTEXT = 2'h0,
      TCSU_OP_RETURN_RESTORE_CONTEXT = 2'h1,
      TCSU_OP_EXTENDED_OPERATION_TRAP = 2'h2,
      TCSU_OP_WS_READ = 2'h3
   } tcsu_op_t;

   typedef struct packed {
      logic valid;
      tcsu_op_t op;
      logic [15:0] operand;
   } tcsu_cmd_t;

   typedef enum logic [2:0] {
      TCSU_KIND_RESET = 3'h0,
      TCSU_KIND_COLD_START = 3'h1,
      TCSU_KIND_INTERRUPT = 3'h2,
      TCSU_KIND_BRANCH_LOAD = 3'h3,
      TCSU_KIND_RETURN = 3'h4,
      TCSU_KIND_EXT_OP = 3'h5,
      TCSU_KIND_WS_READ = 3'h6
   } tcsu_kind_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tcsu_mem_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_FETCH_WS = 3'b001,
      S_FETCH_CTR = 3'b011,
      S_STORE_WS = 3'b010,
      S_STORE_CTR = 3'b110,
      S_STORE_SW = 3'b111,
      S_FETCH_SW = 3'b101,
      S_WS_READ = 3'b100
   } tcsu_state_t;

endpackage

// ### verilog/tcsu_trap_unit.sv
`timescale 1ns/1ps
`include "tcsu_defs.svh"

module tcsu_trap_unit (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins from the external priority encoder
   input wire logic interrupt_request_line_n,
   input wire logic [3:0] interrupt_level_code,
   input wire logic cold_start_request_n,
   // Execution core
   input wire logic instr_fetched,
   input wire logic instr_done,
   input wire logic counter_load,
   input wire logic [15:0] counter_value,
   input wire logic state_word_load,
   input wire logic [15:0] state_word_value,
   input wire tcsu_pkg::tcsu_cmd_t cmd,
   output logic busy,
   output logic [15:0] next_instruction_counter,
   output logic [15:0] processor_state_word,
   output logic [15:0] workspace_pointer,
   output logic [15:0] ws_rdata,
   output logic ws_rdata_valid,
   output logic trap_entered,
   // Memory
   output tcsu_pkg::tcsu_mem_t mem,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack
);

   localparam logic [5:0] PIN_IDLE = `TCSU_PIN_IDLE;

   logic [5:0] pin_raw;
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic [5:0] pin_s3;
   logic [5:0] pin_f;
   logic irq_active;
   logic cold_active;
   logic [3:0] level;
   logic [3:0] interrupt_mask_field;
   logic irq_ok;

   tcsu_pkg::tcsu_state_t state;
   tcsu_pkg::tcsu_kind_t kind;
   logic [3:0] trap_level;
   logic [15:0] new_ws;
   logic [15:0] new_counter;
   logic reset_pending;
   logic inhibit;
   logic commit;

   logic start;
   tcsu_pkg::tcsu_kind_t start_kind;
   logic [15:0] start_addr;

   function automatic logic [15:0] ws_addr(input logic [15:0] base, input logic [3:0] idx);
      ws_addr = base + {11'h000, idx, 1'b0};
   endfunction

   // Three-stage pin synchronisers; a change is taken once stages two and three agree
   assign pin_raw = {cold_start_request_n, interrupt_request_line_n, interrupt_level_code};

   generate
      for (genvar i = 0; i < 6; i++) begin : g_pin
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_s1[i] <= PIN_IDLE[i];
               pin_s2[i] <= PIN_IDLE[i];
               pin_s3[i] <= PIN_IDLE[i];
               pin_f[i] <= PIN_IDLE[i];
            end else begin
               pin_s1[i] <= pin_raw[i];
               pin_s2[i] <= pin_s1[i];
               pin_s3[i] <= pin_s2[i];
               // A one-cycle glitch never lands in the filtered copy
               if (pin_s2[i] == pin_s3[i]) begin
                  pin_f[i] <= pin_s3[i];
               end
            end
         end
      end
   endgenerate

   assign level = pin_f[3:0];
   assign irq_active = ~pin_f[4];
   assign cold_active = ~pin_f[5];
   assign interrupt_mask_field = processor_state_word[`TCSU_MASK_MSB:`TCSU_MASK_LSB];

   // Compared every cycle, taken only at an instruction boundary
   assign irq_ok = irq_active && !inhibit &&
                   ((level <= interrupt_mask_field) ||
                    (level == `TCSU_LEVEL_TOP));

   // Source selection; a core command belongs to the running instruction and so goes first
   always_comb begin
      start = 1'b0;
      start_kind = tcsu_pkg::TCSU_KIND_INTERRUPT;
      start_addr = `TCSU_INT_VEC_BASE;
      if (state == tcsu_pkg::S_IDLE) begin
         if (cmd.valid) begin
            start = 1'b1;
            case (cmd.op)
               tcsu_pkg::TCSU_OP_BRANCH_LOAD_CONTEXT: begin
                  start_kind = tcsu_pkg::TCSU_KIND_BRANCH_LOAD;
                  start_addr = cmd.operand;
               end
               tcsu_pkg::TCSU_OP_RETURN_RESTORE_CONTEXT: begin
                  start_kind = tcsu_pkg::TCSU_KIND_RETURN;
                  start_addr = ws_addr(workspace_pointer, `TCSU_SAVED_WS_REG);
               end
               tcsu_pkg::TCSU_OP_EXTENDED_OPERATION_TRAP: begin
                  start_kind = tcsu_pkg::TCSU_KIND_EXT_OP;
                  start_addr = `TCSU_EXT_OP_VEC_BASE + {10'h000, cmd.operand[3:0], 2'b00};
               end
               tcsu_pkg::TCSU_OP_WS_READ: begin
                  start_kind = tcsu_pkg::TCSU_KIND_WS_READ;
                  start_addr = ws_addr(workspace_pointer, cmd.operand[3:0]);
               end
               default: begin
                  start = 1'b0;
               end
            endcase
         end else if (reset_pending) begin
            start = 1'b1;
            start_kind = tcsu_pkg::TCSU_KIND_RESET;
            start_addr = `TCSU_INT_VEC_BASE;
         end else if (cold_active && instr_done && !inhibit) begin
            start = 1'b1;
            start_kind = tcsu_pkg::TCSU_KIND_COLD_START;
            start_addr = `TCSU_COLD_VEC_WS;
         end else if (irq_ok && instr_done) begin
            start = 1'b1;
            start_kind = tcsu_pkg::TCSU_KIND_INTERRUPT;
            start_addr = `TCSU_INT_VEC_BASE + {10'h000, level, 2'b00};
         end
      end
   end

   // The acknowledge of the third store or third fetch closes every switch
   assign commit = mem_ack && ((state == tcsu_pkg::S_STORE_SW) || (state == tcsu_pkg::S_FETCH_SW));

   // Exchange engine: two vector fetches and three stores in, three fetches back out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= tcsu_pkg::S_IDLE;
         kind <= tcsu_pkg::TCSU_KIND_RESET;
         trap_level <= `TCSU_LEVEL_TOP;
         new_ws <= `TCSU_WS_RESET;
         new_counter <= `TCSU_CTR_RESET;
         mem <= '0;
         busy <= 1'b0;
         ws_rdata <= 16'h0000;
         ws_rdata_valid <= 1'b0;
         trap_entered <= 1'b0;
      end else begin
         ws_rdata_valid <= 1'b0;
         trap_entered <= 1'b0;
         case (state)
            tcsu_pkg::S_IDLE: begin
               if (start) begin
                  kind <= start_kind;
                  // Level is held here; the pins may move once the switch is under way
                  trap_level <= level;
                  busy <= 1'b1;
                  mem.req <= 1'b1;
                  mem.we <= 1'b0;
                  mem.addr <= start_addr;
                  mem.wdata <= 16'h0000;
                  state <= (start_kind == tcsu_pkg::TCSU_KIND_WS_READ) ? tcsu_pkg::S_WS_READ
                                                                       : tcsu_pkg::S_FETCH_WS;
               end
            end
            tcsu_pkg::S_FETCH_WS: begin
               if (mem_ack) begin
                  new_ws <= mem_rdata;
                  mem.addr <= mem.addr + `TCSU_WORD_STEP;
                  state <= tcsu_pkg::S_FETCH_CTR;
               end
            end
            tcsu_pkg::S_FETCH_CTR: begin
               if (mem_ack) begin
                  new_counter <= mem_rdata;
                  if (kind == tcsu_pkg::TCSU_KIND_RETURN) begin
                     // Saved word comes last, so it is committed straight off the bus
                     mem.addr <= ws_addr(workspace_pointer, `TCSU_SAVED_SW_REG);
                     state <= tcsu_pkg::S_FETCH_SW;
                  end else begin
                     mem.we <= 1'b1;
                     mem.addr <= ws_addr(new_ws, `TCSU_SAVED_WS_REG);
                     mem.wdata <= workspace_pointer;
                     state <= tcsu_pkg::S_STORE_WS;
                  end
               end
            end
            tcsu_pkg::S_STORE_WS: begin
               if (mem_ack) begin
                  mem.addr <= mem.addr + `TCSU_WORD_STEP;
                  mem.wdata <= next_instruction_counter;
                  state <= tcsu_pkg::S_STORE_CTR;
               end
            end
            tcsu_pkg::S_STORE_CTR: begin
               if (mem_ack) begin
                  mem.addr <= mem.addr + `TCSU_WORD_STEP;
                  mem.wdata <= processor_state_word;
                  state <= tcsu_pkg::S_STORE_SW;
               end
            end
            tcsu_pkg::S_STORE_SW, tcsu_pkg::S_FETCH_SW: begin
               if (mem_ack) begin
                  mem <= '0;
                  busy <= 1'b0;
                  trap_entered <= (kind == tcsu_pkg::TCSU_KIND_RESET) ||
                                  (kind == tcsu_pkg::TCSU_KIND_COLD_START) ||
                                  (kind == tcsu_pkg::TCSU_KIND_INTERRUPT);
                  state <= tcsu_pkg::S_IDLE;
               end
            end
            tcsu_pkg::S_WS_READ: begin
               if (mem_ack) begin
                  // A register read is no switch, so the context registers stay as they are
                  ws_rdata <= mem_rdata;
                  ws_rdata_valid <= 1'b1;
                  mem <= '0;
                  busy <= 1'b0;
                  state <= tcsu_pkg::S_IDLE;
               end
            end
            default: begin
               mem <= '0;
               busy <= 1'b0;
               state <= tcsu_pkg::S_IDLE;
            end
         endcase
      end
   end

   // Power-up runs the level-0 trap first unless a core command is valid in idle, which goes ahead of it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_pending <= 1'b1;
      end else if (start && (start_kind == tcsu_pkg::TCSU_KIND_RESET)) begin
         reset_pending <= 1'b0;
      end
   end

   // Entering a reset, cold-start or interrupt routine blocks recognition until its first instruction is done; set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inhibit <= 1'b0;
      end else if (commit && (kind == tcsu_pkg::TCSU_KIND_RESET ||
                              kind == tcsu_pkg::TCSU_KIND_COLD_START ||
                              kind == tcsu_pkg::TCSU_KIND_INTERRUPT)) begin
         inhibit <= 1'b1;
      end else if (instr_done) begin
         inhibit <= 1'b0;
      end
   end

   // Workspace base pointer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         workspace_pointer <= `TCSU_WS_RESET;
      end else if (commit) begin
         workspace_pointer <= new_ws;
      end
   end

   // Next-instruction counter; a commit outranks core updates
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         next_instruction_counter <= `TCSU_CTR_RESET;
      end else if (commit) begin
         next_instruction_counter <= new_counter;
      // A jump discards the step of the fetch that carried it
      end else if (counter_load) begin
         next_instruction_counter <= counter_value;
      end else if (instr_fetched) begin
         next_instruction_counter <= next_instruction_counter + `TCSU_CTR_STEP;
      end
   end

   // State word and its mask field
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         processor_state_word <= `TCSU_SW_RESET;
      end else if (commit) begin
         case (kind)
            tcsu_pkg::TCSU_KIND_RETURN: begin
               processor_state_word <= mem_rdata;
            end
            tcsu_pkg::TCSU_KIND_RESET: begin
               processor_state_word <= `TCSU_SW_RESET;
            end
            tcsu_pkg::TCSU_KIND_COLD_START: begin
               processor_state_word[`TCSU_MASK_MSB:`TCSU_MASK_LSB] <= `TCSU_MASK_ZERO;
            end
            tcsu_pkg::TCSU_KIND_INTERRUPT: begin
               // Level 0 would wrap to 15 and open every level, so it stops at zero
               processor_state_word[`TCSU_MASK_MSB:`TCSU_MASK_LSB] <=
                  (trap_level == `TCSU_LEVEL_TOP) ? `TCSU_MASK_ZERO
                                                  : trap_level - `TCSU_LEVEL_STEP;
            end
            tcsu_pkg::TCSU_KIND_BRANCH_LOAD, tcsu_pkg::TCSU_KIND_EXT_OP: begin
               // A called routine runs under its caller's mask; only a return brings back a saved word
               processor_state_word <= processor_state_word;
            end
            default: begin
               processor_state_word <= processor_state_word;
            end
         endcase
      end else if (state_word_load) begin
         processor_state_word <= state_word_value;
      end
   end

endmodule // tcsu_trap_unit

// ### dv/tcsu_trap_unit_asserts.sv
`timescale 1ns/1ps
module tcsu_trap_unit_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Core side
   input wire logic instr_fetched,
   input wire logic instr_done,
   input wire logic counter_load,
   input wire tcsu_pkg::tcsu_cmd_t cmd,
   input wire logic busy,
   input wire logic [15:0] next_instruction_counter,
   input wire logic [15:0] processor_state_word,
   input wire logic [15:0] workspace_pointer,
   input wire logic trap_entered,
   // Memory
   input wire tcsu_pkg::tcsu_mem_t mem,
   input wire logic mem_ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [1:0] st_cnt;
   logic cold_seen;
   logic cmd_go;
   logic [15:0] reg_off;
   assign cmd_go = cmd.valid && !busy;
   assign reg_off = {11'h000, cmd.operand[3:0], 1'b0};
   // Counts acked stores of one switch; back-to-back requests keep req high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_cnt <= 2'h0;
      end else if (!mem.req) begin
         st_cnt <= 2'h0;
      end else if (mem.we && mem_ack) begin
         st_cnt <= st_cnt + 2'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cold_seen <= 1'b0;
      end else if (mem.req && mem_ack && mem.addr == 16'hfffc) begin
         cold_seen <= 1'b1;
      end else if (trap_entered) begin
         cold_seen <= 1'b0;
      end
   end
   sequence s_vec_ack(lo, hi);
      mem.req && !mem.we && mem_ack && mem.addr >= lo && mem.addr < hi && mem.addr[1:0] == 2'h0;
   endsequence
   sequence s_next_read;
      mem.req && !mem.we && mem.addr == $past(mem.addr) + 16'h0002;
   endsequence
   a_int_vec_pair: assert property (s_vec_ack(16'h0000, 16'h0040) |=> s_next_read)
      else $error("interrupt vector words not consecutive");
   a_xop_vec_pair: assert property (s_vec_ack(16'h0040, 16'h0080) |=> s_next_read)
      else $error("extended op vector words not consecutive");
   a_cold_vec_pair: assert property (s_vec_ack(16'hfffc, 16'hfffe) |=> s_next_read)
      else $error("cold start counter not read from fffe");
   a_ctr_step: assert property (instr_fetched && !counter_load && !busy && !cmd.valid && !instr_done
      |=> next_instruction_counter == $past(next_instruction_counter) + 16'h0002)
      else $error("counter did not step by one word");
   a_ws_read_addr: assert property (cmd_go && cmd.op == tcsu_pkg::TCSU_OP_WS_READ
      |=> mem.req && !mem.we && mem.addr == $past(workspace_pointer) + $past(reg_off))
      else $error("register read at wrong address");
   a_store_step: assert property (mem.req && mem.we && mem_ack && st_cnt < 2'h2
      |=> mem.req && mem.we && mem.addr == $past(mem.addr) + 16'h0002)
      else $error("context stores not consecutive");
   a_store_old_ws: assert property (mem.req && mem.we && st_cnt == 2'h0 |-> mem.wdata == workspace_pointer)
      else $error("first store is not the old workspace");
   a_store_old_sw: assert property (mem.req && mem.we && st_cnt == 2'h2 |-> mem.wdata == processor_state_word)
      else $error("third store is not the old state word");
   a_cold_mask: assert property (trap_entered && cold_seen |-> processor_state_word[3:0] == 4'h0)
      else $error("cold start left mask nonzero");
   a_return_restore_context_reload: assert property (cmd_go && cmd.op == tcsu_pkg::TCSU_OP_RETURN_RESTORE_CONTEXT
      |=> mem.req && !mem.we && mem.addr == $past(workspace_pointer) + 16'h001a)
      else $error("return did not read register 13");
endmodule // tcsu_trap_unit_asserts

bind tcsu_trap_unit tcsu_trap_unit_asserts u_tcsu_trap_unit_asserts (.clk, .rst_n, .instr_fetched, .instr_done,
   .counter_load, .cmd, .busy, .next_instruction_counter, .processor_state_word, .workspace_pointer,
   .trap_entered, .mem, .mem_ack);

// ### dv/tcsu_irq_enc.sv
`timescale 1ns/1ps
module tcsu_irq_enc (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Source strobes
   input wire logic [15:0] raise,
   input wire logic [15:0] clear,
   // Pins
   output logic interrupt_request_line_n,
   output logic [3:0] interrupt_level_code
);
   logic [15:0] pend;
   logic [3:0] wander;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 16'h0000;
         wander <= 4'h0;
      end else begin
         pend <= (pend | raise) & ~clear;
         wander <= wander + 4'h1;
      end
   end
   always_comb begin
      interrupt_request_line_n = ~|pend;
      // Code means nothing without a request, so it never sits still
      interrupt_level_code = wander;
      for (int i = 15; i >= 0; i--) begin
         if (pend[i]) begin
            interrupt_level_code = 4'(i);
         end
      end
   end
endmodule // tcsu_irq_enc

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk, rst_n, irq_n, cold_n, fetched, done, c_load, sw_load, busy, rv, trap, ack, pbusy;
   logic [3:0] code;
   logic [15:0] c_val, sw_val, ctr, sw, wp, rdata, mrd, raise, clear, e_wp, e_ctr, e_sw, v;
   tcsu_pkg::tcsu_cmd_t cmd;
   tcsu_pkg::tcsu_mem_t mem;
   logic [15:0] ram[logic [15:0]];
   logic [31:0] wq[$];
   logic [15:0] rq[$];
   logic [36:0] cq[$];
   logic [47:0] stk[$];
   integer seed = 32'h4951;
   int miscompares, check_count;

   tcsu_trap_unit u_tcsu_trap_unit (.clk(clk), .rst_n(rst_n), .interrupt_request_line_n(irq_n),
      .interrupt_level_code(code), .cold_start_request_n(cold_n), .instr_fetched(fetched),
      .instr_done(done), .counter_load(c_load), .counter_value(c_val), .state_word_load(sw_load),
      .state_word_value(sw_val), .cmd(cmd), .busy(busy), .next_instruction_counter(ctr),
      .processor_state_word(sw), .workspace_pointer(wp), .ws_rdata(rdata), .ws_rdata_valid(rv),
      .trap_entered(trap), .mem(mem), .mem_rdata(mrd), .mem_ack(ack));
   tcsu_irq_enc u_tcsu_irq_enc (.clk(clk), .rst_n(rst_n), .raise(raise), .clear(clear),
      .interrupt_request_line_n(irq_n), .interrupt_level_code(code));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cmp_ctx(input string name, input logic [36:0] exp, input logic [36:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic close_out();
      $display("check_count %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Memory: random ack delay; unselected data toggles every cycle
   always @(negedge clk) begin
      ack = 1'b0;
      mrd = ~mrd;
      if (mem.req && ($random(seed) & 3) != 0) begin
         ack = 1'b1;
         if (mem.we) begin
            ram[mem.addr] = mem.wdata;
         end else begin
            mrd = ram.exists(mem.addr) ? ram[mem.addr] : ~mem.addr;
         end
      end
   end

   always @(posedge clk) begin
      pbusy <= busy;
      if (mem.req && mem.we && ack) begin
         cmp_word("store", wq.size() ? wq.pop_front() : 'x, {mem.addr, mem.wdata});
      end
      if (rv) begin
         cmp_word("ws read", rq.size() ? {16'h0, rq.pop_front()} : 'x, {16'h0, rdata});
      end
      if (pbusy && !busy) begin
         cmp_ctx("context", cq.size() ? cq.pop_front() : 'x, {wp, ctr, sw[3:0], trap});
      end
   end

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic irq(input logic [15:0] r, input logic [15:0] c);
      @(negedge clk);
      raise = r;
      clear = c;
      @(negedge clk);
      raise = 16'h0000;
      clear = 16'h0000;
      repeat (8) @(negedge clk);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(negedge clk);
      while (busy !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic do_cmd(input tcsu_pkg::tcsu_op_t op, input logic [15:0] opd);
      @(negedge clk);
      cmd = '{1'b1, op, opd};
      @(negedge clk);
      cmd.valid = 1'b0;
      wait_idle();
   endtask
   // Old context goes to the new workspace; mask becomes m
   task automatic expect_switch(input logic [15:0] va, input logic [3:0] m);
      stk.push_back({e_wp, e_ctr, e_sw});
      wq.push_back({ram[va] + 16'h001a, e_wp});
      wq.push_back({ram[va] + 16'h001c, e_ctr});
      wq.push_back({ram[va] + 16'h001e, e_sw});
      e_wp = ram[va];
      e_ctr = ram[va + 16'h0002];
      e_sw[3:0] = m;
      // Interrupt and cold-start vectors mark the entry of a service routine
      cq.push_back({e_wp, e_ctr, m, (va < 16'h0040) || (va == 16'hfffc)});
   endtask
   task automatic expect_return();
      {e_wp, e_ctr, e_sw} = stk.pop_back();
      cq.push_back({e_wp, e_ctr, e_sw[3:0], 1'b0});
   endtask

   initial begin
      rst_n = 1'b0;
      cold_n = 1'b1;
      {fetched, done, c_load, sw_load, ack} = 5'h00;
      {c_val, sw_val, mrd, raise, clear, e_wp, e_ctr, e_sw} = 128'h0;
      cmd = '0;
      for (int i = 0; i < 16; i++) begin
         ram[16'(i * 4)] = 16'(16'h1000 + i * 32);
         ram[16'(i * 4 + 2)] = 16'(16'h2000 + i * 2);
         ram[16'(i * 4 + 64)] = 16'(16'h1800 + i * 32);
         ram[16'(i * 4 + 66)] = 16'(16'h2800 + i * 2);
      end
      ram[16'hfffc] = 16'h0f00;
      ram[16'hfffe] = 16'h0a00;
      ram[16'h0400] = 16'h0e00;
      ram[16'h0402] = 16'h0c00;
      expect_switch(16'h0000, 4'h0);
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      wait_idle();
      // The reset routine's first instruction lifts the block on interrupts
      pulse(done);
      c_val = 16'($random(seed));
      pulse(c_load);
      pulse(fetched);
      e_ctr = c_val + 16'h0002;
      cmp_word("counter", {16'h0, e_ctr}, {16'h0, ctr});
      for (int l = 0; l < 16; l++) begin
         sw_val = 16'($random(seed));
         pulse(sw_load);
         e_sw = sw_val;
         irq(16'h0001 << l, 16'h0000);
         if (l <= sw_val[3:0]) begin
            expect_switch(16'(l * 4), (l == 0) ? 4'h0 : 4'(l - 1));
         end
         pulse(done);
         wait_idle();
         irq(16'h0000, 16'hffff);
         pulse(done);
      end
      sw_val = 16'h000f;
      pulse(sw_load);
      e_sw = sw_val;
      irq(16'h0200, 16'h0000);
      expect_switch(16'h0024, 4'h8);
      pulse(done);
      wait_idle();
      irq(16'h0008, 16'h0200);
      pulse(done);
      repeat (4) @(negedge clk);
      cmp_word("busy", 32'h0, {31'h0, busy});
      expect_switch(16'h000c, 4'h2);
      pulse(done);
      wait_idle();
      irq(16'h0000, 16'h0008);
      pulse(done);
      expect_return();
      do_cmd(tcsu_pkg::TCSU_OP_RETURN_RESTORE_CONTEXT, 16'h0000);
      @(negedge clk);
      cold_n = 1'b0;
      repeat (8) @(negedge clk);
      expect_switch(16'hfffc, 4'h0);
      pulse(done);
      cold_n = 1'b1;
      wait_idle();
      repeat (8) @(negedge clk);
      expect_switch(16'h0400, e_sw[3:0]);
      do_cmd(tcsu_pkg::TCSU_OP_BRANCH_LOAD_CONTEXT, 16'h0400);
      v = 16'($random(seed)) & 16'h000f;
      expect_switch(16'h0040 + (v << 2), e_sw[3:0]);
      do_cmd(tcsu_pkg::TCSU_OP_EXTENDED_OPERATION_TRAP, v);
      repeat (2) begin
         v = 16'($unsigned($random(seed)) % 13);
         ram[e_wp + (v << 1)] = 16'($random(seed));
         rq.push_back(ram[e_wp + (v << 1)]);
         cq.push_back({e_wp, e_ctr, e_sw[3:0], 1'b0});
         do_cmd(tcsu_pkg::TCSU_OP_WS_READ, {12'($random(seed)), v[3:0]});
      end
      repeat (2) begin
         expect_return();
         do_cmd(tcsu_pkg::TCSU_OP_RETURN_RESTORE_CONTEXT, 16'($random(seed)));
      end
      repeat (10) @(negedge clk);
      cmp_word("leftover", 32'h0, 32'(wq.size() + rq.size() + cq.size()));
      close_out();
   end

   initial begin
      #100000;
      miscompares++;
      close_out();
   end
endmodule // testbench
